// >>> lsbu_core.sv
// logic, shift, rotate and single-bit operation datapath with memory byte access
module lsbu_core
  import lsbu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire lsbu_req_t req_in,
  output logic req_ready_out,
  output logic res_valid_out,
  output lsbu_res_t res_out,
  output lsbu_mem_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [BYTE_W-1:0] mem_rdata_in
);

  lsbu_regs_t regs_r;
  lsbu_regs_t regs_nxt;

  lsbu_req_t cq;
  lsbu_res_t calc;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W-1:0] b_op;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] lg;
  logic [MSB_W-1:0] msb;
  logic [BITNO_W-1:0] pos;
  logic [BYTE_W-1:0] mod_byte;
  logic sel_bit;
  logic is_bit_op;
  logic is_modify;
  logic force_imm;
  logic [DATA_W:0] step1;
  logic [DATA_W:0] step2;

  // one shift or rotate step within the operand size; returns {carry, value}
  function automatic logic [DATA_W:0] shift1(
    input logic [DATA_W-1:0] x,
    input logic [MSB_W-1:0] m,
    input lsbu_op_t op,
    input logic c
  );
    logic [DATA_W-1:0] nx;
    logic co;
    nx = x;
    co = c;
    case (op)
      OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: begin
        nx = {x[DATA_W-2:0], 1'b0};
        co = x[m];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        nx = {1'b0, x[DATA_W-1:1]};
        nx[m] = x[m];
        co = x[0];
      end
      OP_LOGIC_SHIFT_RIGHT: begin
        nx = {1'b0, x[DATA_W-1:1]};
        nx[m] = 1'b0;
        co = x[0];
      end
      OP_ROTATE_LEFT: begin
        nx = {x[DATA_W-2:0], x[m]};
        co = x[m];
      end
      OP_ROTATE_RIGHT: begin
        nx = {1'b0, x[DATA_W-1:1]};
        nx[m] = x[0];
        co = x[0];
      end
      OP_ROTATE_LEFT_THROUGH_CARRY: begin
        nx = {x[DATA_W-2:0], c};
        co = x[m];
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        nx = {1'b0, x[DATA_W-1:1]};
        nx[m] = c;
        co = x[0];
      end
      default: begin
        nx = x;
        co = c;
      end
    endcase
    return {co, nx};
  endfunction : shift1

  // in idle the live request is decoded; later the stored one is
  assign cq = (regs_r.state == ST_IDLE) ? req_in : regs_r.req;
  assign req_ready_out = (regs_r.state == ST_IDLE);
  assign res_valid_out = regs_r.res_valid;
  assign res_out = regs_r.res;
  assign mem_out = regs_r.mem;

  // memory operand only exists while the read is being answered
  assign opnd = (regs_r.state == ST_READ) ? {24'h000000, mem_rdata_in} : cq.dst;
  assign b_op = cq.use_imm ? cq.imm : cq.src;

  assign is_bit_op = (cq.op >= OP_BIT_SET_OP) && (cq.op <= OP_LOAD_INV_BIT_TO_CARRY);
  assign is_modify = (cq.op == OP_BIT_SET_OP) || (cq.op == OP_BIT_CLEAR_OP) ||
                     (cq.op == OP_BIT_INVERT_OP);
  assign force_imm = (cq.op == OP_CARRY_AND_INV_BIT) || (cq.op == OP_CARRY_OR_INV_BIT) ||
                     (cq.op == OP_CARRY_XOR_INV_BIT) || (cq.op == OP_LOAD_INV_BIT_TO_CARRY);

  // inverted carry variants ignore the register bit number
  assign pos = (cq.bit_from_reg && !force_imm) ? cq.bit_reg[BITNO_W-1:0] : cq.bit_imm;

  lsbu_bit_unit u_bit (
    .byte_in(opnd[BYTE_W-1:0]),
    .pos_in(pos),
    .op_in(cq.op),
    .byte_out(mod_byte),
    .bit_out(sel_bit)
  );

  always_comb begin
    unique case (cq.size)
      SZ_BYTE: begin
        msb = MSB_BYTE;
        mask = MASK_BYTE;
      end
      SZ_WORD: begin
        msb = MSB_WORD;
        mask = MASK_WORD;
      end
      SZ_LONG: begin
        msb = MSB_LONG;
        mask = MASK_LONG;
      end
      default: begin
        msb = MSB_LONG;
        mask = MASK_LONG;
      end
    endcase
  end

  // two-position forms chain two single steps so the carry threads through
  assign step1 = shift1(opnd, msb, cq.op, cq.carry);
  assign step2 = cq.shift_two ? shift1(step1[DATA_W-1:0], msb, cq.op, step1[DATA_W])
                              : step1;

  always_comb begin
    lg = opnd;
    calc = '0;
    unique case (cq.op)
      OP_AND: begin
        lg = opnd & b_op;
      end
      OP_OR: begin
        lg = opnd | b_op;
      end
      OP_XOR: begin
        lg = opnd ^ b_op;
      end
      OP_NOT: begin
        lg = ~opnd;
      end
      OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT,
      OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
      OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        lg = step2[DATA_W-1:0];
        calc.c = step2[DATA_W];
        calc.c_we = 1'b1;
      end
      OP_BIT_SET_OP, OP_BIT_CLEAR_OP, OP_BIT_INVERT_OP: begin
        lg = opnd;
      end
      OP_BIT_TEST_OP: begin
        calc.z = ~sel_bit;
        calc.z_we = 1'b1;
      end
      OP_CARRY_AND_BIT: begin
        calc.c = cq.carry & sel_bit;
        calc.c_we = 1'b1;
      end
      OP_CARRY_AND_INV_BIT: begin
        calc.c = cq.carry & ~sel_bit;
        calc.c_we = 1'b1;
      end
      OP_CARRY_OR_BIT: begin
        calc.c = cq.carry | sel_bit;
        calc.c_we = 1'b1;
      end
      OP_CARRY_OR_INV_BIT: begin
        calc.c = cq.carry | ~sel_bit;
        calc.c_we = 1'b1;
      end
      OP_CARRY_XOR_BIT: begin
        calc.c = cq.carry ^ sel_bit;
        calc.c_we = 1'b1;
      end
      OP_CARRY_XOR_INV_BIT: begin
        calc.c = cq.carry ^ ~sel_bit;
        calc.c_we = 1'b1;
      end
      OP_LOAD_BIT_TO_CARRY: begin
        calc.c = sel_bit;
        calc.c_we = 1'b1;
      end
      OP_LOAD_INV_BIT_TO_CARRY: begin
        calc.c = ~sel_bit;
        calc.c_we = 1'b1;
      end
      // undefined codes pass the operand through untouched
      default: begin
        lg = opnd;
      end
    endcase
    if (!is_bit_op) begin
      // upper bits outside the operand size keep the destination's value
      calc.data = (cq.dst & ~mask) | (lg & mask);
      calc.reg_we = 1'b1;
      calc.n = lg[msb];
      calc.n_we = 1'b1;
      calc.z = ((lg & mask) == '0);
      calc.z_we = 1'b1;
      calc.v = 1'b0;
      calc.v_we = 1'b1;
    end else if (is_modify) begin
      if (cq.to_mem) begin
        calc.data = {24'h000000, mod_byte};
        calc.reg_we = 1'b0;
      end else begin
        calc.data = {cq.dst[DATA_W-1:BYTE_W], mod_byte};
        calc.reg_we = 1'b1;
      end
    end else begin
      calc.data = opnd;
      calc.reg_we = 1'b0;
    end
  end

  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.res_valid = 1'b0;
    unique case (regs_r.state)
      ST_IDLE: begin
        if (req_valid_in) begin
          if (is_bit_op && req_in.to_mem) begin
            // memory operand: fetch the byte first
            regs_nxt.req = req_in;
            regs_nxt.state = ST_READ;
            regs_nxt.mem.req = 1'b1;
            regs_nxt.mem.we = 1'b0;
            regs_nxt.mem.addr = req_in.addr;
          end else begin
            regs_nxt.res = calc;
            regs_nxt.res_valid = 1'b1;
          end
        end
      end
      ST_READ: begin
        if (mem_ack_in) begin
          regs_nxt.res = calc;
          if (is_modify) begin
            // whole byte goes back, only the chosen bit differs
            regs_nxt.state = ST_WRITE;
            regs_nxt.mem.we = 1'b1;
            regs_nxt.mem.wdata = mod_byte;
          end else begin
            // test and carry ops leave memory untouched
            regs_nxt.state = ST_IDLE;
            regs_nxt.mem.req = 1'b0;
            regs_nxt.res_valid = 1'b1;
          end
        end
      end
      ST_WRITE: begin
        if (mem_ack_in) begin
          regs_nxt.state = ST_IDLE;
          regs_nxt.mem.req = 1'b0;
          regs_nxt.mem.we = 1'b0;
          regs_nxt.res_valid = 1'b1;
        end
      end
      default: begin
        regs_nxt = REGS_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      regs_r <= REGS_RESET;
    end else begin
      regs_r <= regs_nxt;
    end
  end

endmodule : lsbu_core

// >>> lsbu_pkg.sv
// shared types and constants of the logic, shift and bit operation unit
package lsbu_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BITNO_W = 3;
  localparam int unsigned MSB_W = 5;

  localparam logic [MSB_W-1:0] MSB_BYTE = 5'h07;
  localparam logic [MSB_W-1:0] MSB_WORD = 5'h0F;
  localparam logic [MSB_W-1:0] MSB_LONG = 5'h1F;

  localparam logic [DATA_W-1:0] MASK_BYTE = 32'h000000FF;
  localparam logic [DATA_W-1:0] MASK_WORD = 32'h0000FFFF;
  localparam logic [DATA_W-1:0] MASK_LONG = 32'hFFFFFFFF;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } lsbu_size_t;

  typedef enum logic [4:0] {
    OP_AND = 5'h00,
    OP_OR = 5'h01,
    OP_XOR = 5'h02,
    OP_NOT = 5'h03,
    OP_ARITH_SHIFT_LEFT = 5'h04,
    OP_ARITH_SHIFT_RIGHT = 5'h05,
    OP_LOGIC_SHIFT_LEFT = 5'h06,
    OP_LOGIC_SHIFT_RIGHT = 5'h07,
    OP_ROTATE_LEFT = 5'h08,
    OP_ROTATE_RIGHT = 5'h09,
    OP_ROTATE_LEFT_THROUGH_CARRY = 5'h0A,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h0B,
    OP_BIT_SET_OP = 5'h0C,
    OP_BIT_CLEAR_OP = 5'h0D,
    OP_BIT_INVERT_OP = 5'h0E,
    OP_BIT_TEST_OP = 5'h0F,
    OP_CARRY_AND_BIT = 5'h10,
    OP_CARRY_AND_INV_BIT = 5'h11,
    OP_CARRY_OR_BIT = 5'h12,
    OP_CARRY_OR_INV_BIT = 5'h13,
    OP_CARRY_XOR_BIT = 5'h14,
    OP_CARRY_XOR_INV_BIT = 5'h15,
    OP_LOAD_BIT_TO_CARRY = 5'h16,
    OP_LOAD_INV_BIT_TO_CARRY = 5'h17
  } lsbu_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } lsbu_state_t;

  typedef struct packed {
    lsbu_op_t op;
    lsbu_size_t size;
    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] src;
    logic [DATA_W-1:0] imm;
    logic use_imm;
    logic shift_two;
    logic [BITNO_W-1:0] bit_imm;
    logic [BYTE_W-1:0] bit_reg;
    logic bit_from_reg;
    logic to_mem;
    logic [ADDR_W-1:0] addr;
    logic carry;
  } lsbu_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic reg_we;
    logic c;
    logic c_we;
    logic z;
    logic z_we;
    logic n;
    logic n_we;
    logic v;
    logic v_we;
  } lsbu_res_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } lsbu_mem_t;

  typedef struct packed {
    lsbu_state_t state;
    lsbu_req_t req;
    lsbu_res_t res;
    logic res_valid;
    lsbu_mem_t mem;
  } lsbu_regs_t;

  localparam lsbu_regs_t REGS_RESET = '{state: ST_IDLE, default: '0};

endpackage : lsbu_pkg

// >>> lsbu_bit_unit.sv
// single-bit select and modify on one byte operand
module lsbu_bit_unit
  import lsbu_pkg::*;
(
  input wire logic [BYTE_W-1:0] byte_in,
  input wire logic [BITNO_W-1:0] pos_in,
  input wire lsbu_op_t op_in,
  output logic [BYTE_W-1:0] byte_out,
  output logic bit_out
);

  always_comb begin
    byte_out = byte_in;
    bit_out = byte_in[pos_in];
    case (op_in)
      OP_BIT_SET_OP: begin
        byte_out[pos_in] = 1'b1;
      end
      OP_BIT_CLEAR_OP: begin
        byte_out[pos_in] = 1'b0;
      end
      OP_BIT_INVERT_OP: begin
        byte_out[pos_in] = ~byte_in[pos_in];
      end
      // test and carry ops never change the operand
      default: begin
        byte_out = byte_in;
      end
    endcase
  end

endmodule : lsbu_bit_unit

// >>> lsbu_core_checker.sv
// assertion checker for the logic, shift and bit operation datapath
module lsbu_core_checker
  import lsbu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire lsbu_req_t req_in,
  input wire logic req_ready_out,
  input wire logic res_valid_out,
  input wire lsbu_res_t res_out,
  input wire lsbu_mem_t mem_out,
  input wire logic mem_ack_in,
  input wire logic [BYTE_W-1:0] mem_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire tk = req_valid_in && req_ready_out;
  wire tm = tk && req_in.to_mem && req_in.op >= OP_BIT_SET_OP;
  wire rl = tk && !req_in.to_mem && req_in.size == SZ_LONG;
  property p_reg;
    tk && !tm |=> res_valid_out;
  endproperty
  a_reg: assert property (p_reg) else $error("no register result");
  property p_and;
    rl && req_in.op == OP_AND && !req_in.use_imm |=> res_out.data == $past(req_in.dst & req_in.src);
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_not;
    rl && req_in.op == OP_NOT |=> res_out.data == ~$past(req_in.dst);
  endproperty
  a_not: assert property (p_not) else $error("complement wrong");
  property p_tst;
    tk && !req_in.to_mem && req_in.op == OP_BIT_TEST_OP && !req_in.bit_from_reg
      |=> res_out.z_we && res_out.z == $past(~req_in.dst[req_in.bit_imm]);
  endproperty
  a_tst: assert property (p_tst) else $error("bit test zero wrong");
  property p_rd;
    tm |=> mem_out.req && !mem_out.we && mem_out.addr == $past(req_in.addr);
  endproperty
  a_rd: assert property (p_rd) else $error("memory read missing");
  property p_hold;
    mem_out.req && !mem_ack_in |=> $stable(mem_out);
  endproperty
  a_hold: assert property (p_hold) else $error("memory request moved");
  property p_wr;
    mem_out.req && mem_out.we && mem_ack_in |=> !mem_out.req && res_valid_out && !res_out.reg_we;
  endproperty
  a_wr: assert property (p_wr) else $error("write end wrong");
  property p_done;
    tm |-> ##[2:30] res_valid_out;
  endproperty
  a_done: assert property (p_done) else $error("memory op never ended");
endmodule : lsbu_core_checker

bind lsbu_core lsbu_core_checker lsbu_core_checker_i (.sys_clk_in, .sys_rst_in, .req_valid_in,
  .req_in, .req_ready_out, .res_valid_out, .res_out, .mem_out, .mem_ack_in, .mem_rdata_in);

// >>> lsbu_mem_model.sv
// behavioural byte memory answering the datapath's memory port
module lsbu_mem_model
  import lsbu_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire lsbu_mem_t mem_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [BYTE_W-1:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [BYTE_W-1:0] mem [16];
  logic [BYTE_W-1:0] last_r;
  logic [1:0] wait_r;
  // slow mode holds the answer off two cycles so the request must stand
  assign ack_out = mem_in.req && (wait_r == (slow_in ? 2'h2 : 2'h0));
  // outside a read answer the byte is wrong on purpose
  assign rdata_out = (ack_out && !mem_in.we) ? mem[mem_in.addr[3:0]] : ~last_r;
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_r <= 2'h0;
      last_r <= 8'h00;
    end else begin
      wait_r <= (!mem_in.req || ack_out) ? 2'h0 : wait_r + 2'h1;
      if (ack_out)
        last_r <= rdata_out;
      if (ack_out && mem_in.we)
        mem[mem_in.addr[3:0]] <= mem_in.wdata;
    end
  end
endmodule : lsbu_mem_model

// >>> testbench.sv
// self-checking bench of the logic, shift and bit operation datapath
module testbench
  import lsbu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic slow = 1'b0;
  lsbu_req_t req_in = '0;
  lsbu_req_t r;
  lsbu_res_t rs;
  logic req_ready_out, res_valid_out, mem_ack_in;
  lsbu_res_t res_out;
  lsbu_mem_t mem_out;
  logic [BYTE_W-1:0] mem_rdata_in;
  int failures = 0;
  int n_tests = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  lsbu_core lsbu_core_i (.sys_clk_in, .sys_rst_in, .req_valid_in, .req_in, .req_ready_out,
    .res_valid_out, .res_out, .mem_out, .mem_ack_in, .mem_rdata_in);
  lsbu_mem_model lsbu_mem_model_i (.sys_clk_in, .sys_rst_in, .mem_in(mem_out), .slow_in(slow),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // one request at a time; the result is sampled in the cycle its valid pulse is high
  task automatic go();
    int k;
    k = 0;
    @(posedge sys_clk_in);
    #1;
    req_in = r;
    req_valid_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    req_valid_in = 1'b0;
    while (res_valid_out !== 1'b1 && k < 40) begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end
    rs = res_out;
    chk("result_valid", res_valid_out, 1'b1);
  endtask : go
  function automatic void q(lsbu_op_t op, lsbu_size_t sz, logic [31:0] d, logic [31:0] s);
    r = '0;
    r.op = op;
    r.size = sz;
    r.dst = d;
    r.src = s;
    r.imm = ~s;
  endfunction : q
  task automatic lg(lsbu_op_t op, lsbu_size_t sz, logic [31:0] d, logic [31:0] s, logic ui,
    logic [31:0] e, logic [1:0] nz);
    q(op, sz, d, ui ? ~s : s);
    r.use_imm = ui;
    go();
    chk("data", rs.data, e);
    chk("flags", {rs.reg_we, rs.n_we, rs.z_we, rs.v_we, rs.v, rs.n, rs.z}, {5'h1E, nz});
  endtask : lg
  task automatic sh(lsbu_op_t op, logic two, logic ci, logic [7:0] e, logic ec);
    q(op, SZ_BYTE, 32'h12345681, 32'h0);
    r.shift_two = two;
    r.carry = ci;
    go();
    chk("shift", rs.data, {24'h123456, e});
    chk("shift_c", {rs.c_we, rs.c}, {1'b1, ec});
  endtask : sh
  task automatic bt(lsbu_op_t op, logic [2:0] b, logic fr, logic [7:0] br, logic tm);
    q(op, SZ_BYTE, tm ? 32'h0 : 32'hA5, 32'h0);
    r.bit_imm = b;
    r.bit_from_reg = fr;
    r.bit_reg = br;
    r.to_mem = tm;
    r.addr = 32'h3;
    go();
  endtask : bt
  task automatic t_logic();
    lg(OP_AND, SZ_LONG, 32'hF0F0A5A5, 32'h3C3C0FF0, 1'b0, 32'h303005A0, 2'h0);
    lg(OP_AND, SZ_BYTE, 32'h12345670, 32'h0F, 1'b1, 32'h12345600, 2'h1);
    lg(OP_OR, SZ_WORD, 32'hFFFF0101, 32'h1010, 1'b0, 32'hFFFF1111, 2'h0);
    lg(OP_XOR, SZ_LONG, 32'hAAAA5555, 32'h0000FFFF, 1'b1, 32'hAAAAAAAA, 2'h2);
    lg(OP_NOT, SZ_BYTE, 32'h12345670, 32'h0, 1'b0, 32'h1234568F, 2'h2);
    lg(OP_NOT, SZ_LONG, 32'h0F0F00FF, 32'h0, 1'b0, 32'hF0F0FF00, 2'h2);
    $display("logic done");
  endtask : t_logic
  task automatic t_shift();
    sh(OP_ARITH_SHIFT_LEFT, 1'b1, 1'b1, 8'h04, 1'b0);
    sh(OP_ARITH_SHIFT_RIGHT, 1'b0, 1'b0, 8'hC0, 1'b1);
    sh(OP_ARITH_SHIFT_RIGHT, 1'b1, 1'b0, 8'hE0, 1'b0);
    sh(OP_LOGIC_SHIFT_LEFT, 1'b0, 1'b0, 8'h02, 1'b1);
    sh(OP_LOGIC_SHIFT_RIGHT, 1'b1, 1'b1, 8'h20, 1'b0);
    sh(OP_ROTATE_LEFT, 1'b1, 1'b0, 8'h06, 1'b0);
    sh(OP_ROTATE_RIGHT, 1'b0, 1'b0, 8'hC0, 1'b1);
    sh(OP_ROTATE_LEFT_THROUGH_CARRY, 1'b1, 1'b0, 8'h05, 1'b0);
    sh(OP_ROTATE_LEFT_THROUGH_CARRY, 1'b0, 1'b1, 8'h03, 1'b1);
    sh(OP_ROTATE_RIGHT_THROUGH_CARRY, 1'b1, 1'b0, 8'hA0, 1'b0);
    $display("shift done");
  endtask : t_shift
  task automatic t_bit();
    bt(OP_BIT_SET_OP, 3'h1, 1'b0, 8'h00, 1'b0);
    chk("set_bit", rs.data[7:0], 8'hA7);
    bt(OP_BIT_CLEAR_OP, 3'h5, 1'b1, 8'hF8, 1'b0);
    chk("clear_bit", rs.data[7:0], 8'hA4);
    bt(OP_BIT_INVERT_OP, 3'h7, 1'b0, 8'h00, 1'b0);
    chk("invert_bit", rs.data[7:0], 8'h25);
    bt(OP_BIT_TEST_OP, 3'h2, 1'b1, 8'h09, 1'b0);
    chk("test_bit", rs.z, 1'b1);
    chk("test_we", {rs.reg_we, rs.z_we, rs.c_we}, 3'h2);
    bt(OP_BIT_TEST_OP, 3'h0, 1'b0, 8'h00, 1'b0);
    chk("test_imm", rs.z, 1'b0);
    $display("bit done");
  endtask : t_bit
  // every carry op with both bit values and both carry values
  task automatic t_carry();
    logic v;
    logic e;
    for (int i = 0; i < 32; i++) begin
      q(lsbu_op_t'(5'h10 + {2'h0, i[4:2]}), SZ_BYTE, i[1] ? 32'h10 : 32'hEF, 32'h0);
      r.bit_imm = 3'h4;
      r.carry = i[0];
      go();
      v = i[1] ^ i[2];
      case (i[4:3])
        2'h0: e = i[0] & v;
        2'h1: e = i[0] | v;
        2'h2: e = i[0] ^ v;
        default: e = v;
      endcase
      chk("carry", rs.c, e);
    end
    // carry set so that the register bit number would give a different answer
    q(OP_CARRY_AND_INV_BIT, SZ_BYTE, 32'hA5, 32'h0);
    r.bit_from_reg = 1'b1;
    r.bit_reg = 8'h04;
    r.carry = 1'b1;
    go();
    chk("inv_imm", rs.c, 1'b0);
    $display("carry done");
  endtask : t_carry
  task automatic t_mem();
    lsbu_mem_model_i.mem[3] = 8'h5A;
    bt(OP_BIT_SET_OP, 3'h0, 1'b0, 8'h00, 1'b1);
    chk("mset", lsbu_mem_model_i.mem[3], 8'h5B);
    chk("mres", rs.data, 32'h5B);
    chk("mres_we", {rs.reg_we, rs.c_we, rs.z_we}, 3'h0);
    slow = 1'b1;
    bt(OP_BIT_INVERT_OP, 3'h7, 1'b0, 8'h00, 1'b1);
    chk("mnot", lsbu_mem_model_i.mem[3], 8'hDB);
    bt(OP_BIT_CLEAR_OP, 3'h6, 1'b1, 8'h00, 1'b1);
    chk("mclr", lsbu_mem_model_i.mem[3], 8'hDA);
    bt(OP_BIT_TEST_OP, 3'h2, 1'b0, 8'h00, 1'b1);
    chk("mtst", {rs.z, lsbu_mem_model_i.mem[3]}, 9'h1DA);
    slow = 1'b0;
    bt(OP_LOAD_INV_BIT_TO_CARRY, 3'h1, 1'b0, 8'h00, 1'b1);
    chk("mld", rs.c, 1'b0);
    $display("memory done");
  endtask : t_mem
  // a reset in the middle of a memory operation must drop it cleanly
  task automatic t_reset();
    q(OP_BIT_SET_OP, SZ_BYTE, 32'h0, 32'h0);
    r.to_mem = 1'b1;
    r.addr = 32'h3;
    slow = 1'b1;
    @(posedge sys_clk_in);
    #1;
    req_in = r;
    req_valid_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    req_valid_in = 1'b0;
    chk("busy", {req_ready_out, mem_out.req, mem_out.we}, 3'h2);
    sys_rst_in = 1'b1;
    #1;
    chk("rst_state", {req_ready_out, res_valid_out, mem_out.req}, 3'h4);
    chk("rst_data", res_out.data, 32'h0);
    @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    slow = 1'b0;
    lg(OP_OR, SZ_BYTE, 32'h0, 32'h80, 1'b0, 32'h80, 2'h2);
    $display("reset done");
  endtask : t_reset
  initial begin
    repeat (2) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_logic();
    t_shift();
    t_bit();
    t_carry();
    t_mem();
    t_reset();
    end_of_test();
  end
  // whole run is near 150 cycles; this span is far beyond it
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : testbench
